// *** pkg/mpkc_pkg.sv ***
`default_nettype none
package mpkc_pkg;
  // Timing.
  localparam int CLK_MHZ = 10;
  localparam int DEBOUNCE_US = 10000;
  localparam int DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
  localparam int EXT_MANUAL_TRIGGER_KEY_MIN_US = 100;
  localparam int EXT_MANUAL_TRIGGER_KEY_MIN_CYC = EXT_MANUAL_TRIGGER_KEY_MIN_US * CLK_MHZ;
  // Half the least pulse width leaves margin for a slow source.
  localparam int EXT_MANUAL_TRIGGER_KEY_FILT_CYC = EXT_MANUAL_TRIGGER_KEY_MIN_CYC / 2;
  // Key vector positions.
  localparam int K_SHIFT = 0;
  localparam int K_DCV = 1;
  localparam int K_ACV = 2;
  localparam int K_OHM = 3;
  localparam int K_DCI = 4;
  localparam int K_ACI = 5;
  localparam int K_RANGE = 6;
  localparam int K_DOWN = 7;
  localparam int K_UP = 8;
  localparam int K_RATE = 9;
  localparam int K_SMOOTH = 10;
  localparam int K_MANUAL_TRIGGER_KEY = 11;
  localparam int K_NULL = 12;
  localparam int K_HOLD = 13;
  localparam int K_CAL = 14;
  localparam int NKEYS = 15;
  // Measurement functions.
  localparam logic [2:0] FN_DCV = 3'h0;
  localparam logic [2:0] FN_ACV = 3'h1;
  localparam logic [2:0] FN_OHM2 = 3'h2;
  localparam logic [2:0] FN_OHM4 = 3'h3;
  localparam logic [2:0] FN_DCI = 3'h4;
  localparam logic [2:0] FN_ACI = 3'h5;
  localparam int NFUNC = 6;
  localparam logic [2:0] TOP_DCV = 3'h5;
  localparam logic [2:0] TOP_ACV = 3'h3;
  localparam logic [2:0] TOP_OHM = 3'h6;
  localparam logic [2:0] TOP_CUR = 3'h1;
  // Rate index 0 is the maximum speed, 1..6 the slower levels x2..x100.
  localparam logic [2:0] RATE_FAST = 3'h0;
  localparam logic [2:0] RATE_SLOWEST = 3'h6;
  // Smoothing count index 0..6 stands for 1, 2, 5, 10, 20, 50, 100.
  localparam logic [2:0] SMOOTH_MIN = 3'h0;
  localparam logic [2:0] SMOOTH_MAX = 3'h6;
  localparam logic [1:0] DIG_3H = 2'h0;
  localparam logic [1:0] DIG_4H = 2'h1;
  localparam logic [1:0] DIG_5H = 2'h2;
  localparam logic [2:0] CURSOR_MAX = 3'h5;
  // Register map and reset values.
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam int CTRL_REMOTE_BIT = 0;
  localparam logic [2:0] RST_FUNC = FN_DCV;
  localparam logic [1:0] RST_DIGITS = DIG_5H;
  localparam logic RST_AUTO = 1'b1;

  typedef enum logic [1:0] {
    MPKC_MEAS = 2'b00,
    MPKC_SET_RATE = 2'b01,
    MPKC_SET_SMOOTH = 2'b11,
    MPKC_REMOTE = 2'b10
  } mpkc_mode_e;

  function automatic logic [2:0] mpkc_range_top(input logic [2:0] fn);
    logic [2:0] t;
    t = TOP_CUR;
    case (fn)
      FN_DCV: t = TOP_DCV;
      FN_ACV: t = TOP_ACV;
      FN_OHM2, FN_OHM4: t = TOP_OHM;
      default: t = TOP_CUR;
    endcase
    return t;
  endfunction
endpackage
`default_nettype wire

// *** rtl/mpkc_key_ctrl.sv ***
// Design decisions made here: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module mpkc_key_ctrl
  import mpkc_pkg::*;
#(
  parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Avalon-MM slave
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Panel keys, switches and trigger
  input wire logic [NKEYS-1:0] keys_in,
  input wire logic ext_manual_trigger_key_n_in,
  input wire logic line_sel_60_in,
  input wire logic [3:0] cal_pos_in,
  // Measurement settings
  output logic [2:0] func_out,
  output logic [2:0] range_out,
  output logic auto_range_out,
  output logic [1:0] digits_out,
  output logic [2:0] rate_out,
  output logic smooth_on_out,
  output logic [2:0] smooth_idx_out,
  output logic hold_out,
  output logic buzzer_on_out,
  output logic null_on_out,
  // Display indications
  output logic shift_marker_out,
  output logic remote_out,
  output logic [1:0] set_mode_out,
  output logic [2:0] set_value_out,
  output logic power_up_disp_out,
  output logic line_60_out,
  output logic cal_pos_ind_out,
  output logic [3:0] cal_pos_out,
  output logic cal_enable_out,
  output logic [2:0] cal_cursor_out,
  // Sequencer strobes
  output logic meas_start_out,
  output logic null_capture_out
);

  typedef struct packed {
    mpkc_mode_e mode;
    logic [NFUNC-1:0][2:0] rng;
    logic [2:0] func;
    logic [2:0] rng_cur;
    logic autor;
    logic [1:0] digits;
    logic [2:0] rate;
    logic smon;
    logic [2:0] smidx;
    logic [2:0] edit;
    logic hold;
    logic buz;
    logic nullon;
    logic shift;
    logic cal_en;
    logic [2:0] cursor;
    logic caught;
    logic line60;
    logic pwr_disp;
    logic calind;
    logic [3:0] calpos;
    logic [19:0] tick_cnt;
    logic [NKEYS-1:0] smp;
    logic [NKEYS-1:0] deb;
    logic [NKEYS-1:0] deb_d;
    logic [9:0] manual_trigger_key_cnt;
    logic wait_req;
    logic [31:0] rdata;
    logic meas_start;
    logic null_cap;
    logic remote;
  } mpkc_state_s;

  logic rs_meta;
  logic rst_n;
  mpkc_state_s st;
  mpkc_state_s next_st;
  logic [NKEYS-1:0] press;
  logic tick;
  logic ext_fire;
  logic bus_wr;
  logic [2:0] top;

  // The reset is released through two stages so its removal is synchronous.
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rs_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rs_meta <= 1'b1;
      rst_n <= rs_meta;
    end
  end

  assign press = st.deb & ~st.deb_d;
  assign tick = (st.tick_cnt == 20'(DEBOUNCE_CYCLES - 1));
  assign ext_fire = !ext_manual_trigger_key_n_in && (st.manual_trigger_key_cnt == 10'(EXT_MANUAL_TRIGGER_KEY_FILT_CYC - 1));
  assign bus_wr = avs_write_in && !st.wait_req;
  assign top = mpkc_range_top(st.func);

  always_comb
  begin
    next_st = st;
    next_st.meas_start = 1'b0;
    next_st.null_cap = 1'b0;
    // Keys are sampled only at the debounce tick, so contact bounce never reaches press.
    next_st.tick_cnt = tick ? 20'h0 : st.tick_cnt + 20'h1;
    next_st.deb_d = st.deb;
    if (tick)
    begin
      next_st.smp = keys_in;
      next_st.deb = (st.smp & keys_in) | (st.deb & (st.smp | keys_in));
    end
    if (!st.caught)
    begin
      next_st.caught = 1'b1;
      next_st.line60 = line_sel_60_in;
      next_st.pwr_disp = 1'b1;
    end
    else if (|press)
      next_st.pwr_disp = 1'b0;
    next_st.calpos = cal_pos_in;
    next_st.calind = (cal_pos_in != 4'h0);
    if (ext_manual_trigger_key_n_in)
      next_st.manual_trigger_key_cnt = 10'h0;
    else if (st.manual_trigger_key_cnt != 10'(EXT_MANUAL_TRIGGER_KEY_FILT_CYC))
      next_st.manual_trigger_key_cnt = st.manual_trigger_key_cnt + 10'h1;
    case (st.mode)
      MPKC_REMOTE:
      begin
        if (press[K_SHIFT])
        begin
          next_st.mode = MPKC_MEAS;
          next_st.shift = 1'b0;
        end
      end
      MPKC_SET_RATE, MPKC_SET_SMOOTH:
      begin
        if (press[K_DOWN] && st.edit != 3'h0)
          next_st.edit = st.edit - 3'h1;
        else if (press[K_UP] && st.edit != ((st.mode == MPKC_SET_RATE) ? RATE_SLOWEST : SMOOTH_MAX))
          next_st.edit = st.edit + 3'h1;
        if (press[K_SHIFT])
        begin
          if (st.mode == MPKC_SET_RATE)
            next_st.rate = st.edit;
          else
            next_st.smidx = st.edit;
          next_st.meas_start = 1'b1;
          next_st.mode = MPKC_MEAS;
          next_st.shift = 1'b0;
        end
      end
      default:
      begin
        if (press[K_SHIFT])
          next_st.shift = !st.shift;
        if (press[K_DCV])
          next_st.func = FN_DCV;
        if (press[K_ACV])
          next_st.func = FN_ACV;
        if (press[K_OHM])
          next_st.func = st.shift ? FN_OHM4 : FN_OHM2;
        if (press[K_DCI])
          next_st.func = FN_DCI;
        if (press[K_ACI])
          next_st.func = FN_ACI;
        if (press[K_RANGE])
        begin
          if (st.cal_en)
            next_st.cursor = (st.cursor == CURSOR_MAX) ? 3'h0 : st.cursor + 3'h1;
          else if (st.shift)
            next_st.digits = DIG_3H;
          else
            next_st.autor = !st.autor;
        end
        if (press[K_DOWN])
        begin
          if (st.shift)
            next_st.digits = DIG_4H;
          else
          begin
            next_st.autor = 1'b0;
            if (st.rng[st.func] != 3'h0)
              next_st.rng[st.func] = st.rng[st.func] - 3'h1;
          end
        end
        if (press[K_UP])
        begin
          if (st.shift)
            next_st.digits = DIG_5H;
          else
          begin
            next_st.autor = 1'b0;
            if (st.rng[st.func] < top)
              next_st.rng[st.func] = st.rng[st.func] + 3'h1;
          end
        end
        if (press[K_RATE])
        begin
          if (st.shift)
          begin
            next_st.mode = MPKC_SET_RATE;
            next_st.edit = st.rate;
          end
          else
          begin
            next_st.rate = RATE_FAST;
            next_st.meas_start = 1'b1;
          end
        end
        if (press[K_SMOOTH])
        begin
          if (st.shift)
          begin
            next_st.mode = MPKC_SET_SMOOTH;
            next_st.edit = st.smidx;
          end
          else
            next_st.smon = !st.smon;
        end
        if (press[K_MANUAL_TRIGGER_KEY])
        begin
          if (st.shift)
            next_st.buz = !st.buz;
          else if (st.hold)
            next_st.meas_start = 1'b1;
        end
        if (press[K_NULL])
        begin
          next_st.null_cap = 1'b1;
          next_st.nullon = 1'b1;
        end
        if (press[K_HOLD])
          next_st.hold = !st.hold;
        if (press[K_CAL])
          next_st.cal_en = !st.cal_en;
      end
    endcase
    if (ext_fire && st.hold)
      next_st.meas_start = 1'b1;
    // A write to the control word switches between local and remote control.
    if (bus_wr && avs_address_in == REG_CTRL)
      next_st.mode = avs_writedata_in[CTRL_REMOTE_BIT] ? MPKC_REMOTE : MPKC_MEAS;
    next_st.rng_cur = next_st.rng[next_st.func];
    next_st.remote = (next_st.mode == MPKC_REMOTE);
    // Each access waits exactly one cycle; unmapped reads return zero.
    next_st.wait_req = !((avs_read_in || avs_write_in) && st.wait_req);
    if ((avs_read_in || avs_write_in) && st.wait_req)
    begin
      case (avs_address_in)
        REG_CTRL: next_st.rdata = {31'h0, st.mode == MPKC_REMOTE};
        REG_STATUS: next_st.rdata = {1'b0, st.mode, st.line60, st.calpos, st.cursor,
          st.cal_en, st.nullon, st.buz, st.shift, st.hold, st.smidx, st.smon, st.rate,
          st.digits, st.autor, st.rng_cur, st.func};
        default: next_st.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
      st.mode <= MPKC_MEAS;
      st.func <= RST_FUNC;
      st.digits <= RST_DIGITS;
      st.autor <= RST_AUTO;
      st.wait_req <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign avs_readdata_out = st.rdata;
  assign avs_waitrequest_out = st.wait_req;
  assign func_out = st.func;
  assign range_out = st.rng_cur;
  assign auto_range_out = st.autor;
  assign digits_out = st.digits;
  assign rate_out = st.rate;
  assign smooth_on_out = st.smon;
  assign smooth_idx_out = st.smidx;
  assign hold_out = st.hold;
  assign buzzer_on_out = st.buz;
  assign null_on_out = st.nullon;
  assign shift_marker_out = st.shift;
  assign remote_out = st.remote;
  assign set_mode_out = st.mode;
  assign set_value_out = st.edit;
  assign power_up_disp_out = st.pwr_disp;
  assign line_60_out = st.line60;
  assign cal_pos_ind_out = st.calind;
  assign cal_pos_out = st.calpos;
  assign cal_enable_out = st.cal_en;
  assign cal_cursor_out = st.cursor;
  assign meas_start_out = st.meas_start;
  assign null_capture_out = st.null_cap;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n);

  logic ctrl_wr;
  assign ctrl_wr = bus_wr && avs_address_in == REG_CTRL;

  sequence set_commit_s;
    st.mode == MPKC_SET_RATE && press[K_SHIFT] && !ctrl_wr;
  endsequence
  sequence committed_s;
    meas_start_out && rate_out == $past(st.edit) && set_mode_out == MPKC_MEAS;
  endsequence

  shift_toggle_a: assert property ((st.mode == MPKC_MEAS && press[K_SHIFT]) |=>
    shift_marker_out != $past(shift_marker_out)) else $error("shift did not toggle");
  rate_commit_a: assert property (set_commit_s |=> committed_s)
    else $error("rate commit failed");
  local_return_a: assert property ((st.mode == MPKC_REMOTE && press[K_SHIFT] && !ctrl_wr)
    |=> !remote_out) else $error("no return to local");
  func_restore_a: assert property ((st.mode == MPKC_MEAS && press == NKEYS'(1 << K_DCV))
    |=> func_out == FN_DCV && range_out == $past(st.rng[FN_DCV]))
    else $error("function range not restored");
  down_manual_a: assert property ((st.mode == MPKC_MEAS && press == NKEYS'(1 << K_DOWN)
    && !st.shift && !ext_fire) |=> !auto_range_out &&
    range_out == (($past(range_out) == 3'h0) ? 3'h0 : $past(range_out) - 3'h1))
    else $error("down range step wrong");
  up_clamp_a: assert property ((st.mode == MPKC_MEAS && press == NKEYS'(1 << K_UP)
    && !st.shift && range_out == top) |=> $stable(range_out))
    else $error("range passed its top");
  ext_hold_a: assert property ((ext_fire && !st.hold && press == '0)
    |=> !meas_start_out) else $error("trigger honoured outside hold");
  one_shot_a: assert property (press[K_MANUAL_TRIGGER_KEY] |-> $past(keys_in[K_MANUAL_TRIGGER_KEY]) ##1
    !press[K_MANUAL_TRIGGER_KEY]) else $error("key press without key or repeated");
  power_line_a: assert property ($rose(st.caught) |-> power_up_disp_out &&
    line_60_out == $past(line_sel_60_in)) else $error("line setting not shown");
  digits_4h_a: assert property ((st.mode == MPKC_MEAS && press == NKEYS'(1 << K_DOWN)
    && st.shift) |=> digits_out == DIG_4H) else $error("4-1/2 digits not set");
  cal_ind_a: assert property ((cal_pos_in != 4'h0) |=> cal_pos_ind_out)
    else $error("cal position not indicated");
  bus_wait_a: assert property ((avs_read_in && avs_waitrequest_out) |=> !avs_waitrequest_out)
    else $error("slave answer late");

endmodule
`default_nettype wire

// *** testbench/mpkc_panel_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module mpkc_panel_model
  import mpkc_pkg::*;
(
  // Clock
  input wire logic clk_in,
  // Operator keys and trigger source
  output logic [NKEYS-1:0] keys_out,
  output logic ext_manual_trigger_key_n_out
);
  initial
  begin
    keys_out = {NKEYS{1'b0}};
    ext_manual_trigger_key_n_out = 1'b1;
  end

  // Each press is followed by enough idle time for two low debounce samples.
  task automatic press(input int k, input int hi);
    @(posedge clk_in);
    keys_out[k] <= 1'b1;
    repeat (hi) @(posedge clk_in);
    keys_out[k] <= 1'b0;
    repeat (16) @(posedge clk_in);
  endtask

  // Active-low pulse; widths under 500 cycles are sent only to test refusal.
  task automatic manual_trigger_key_pulse(input int lo);
    @(posedge clk_in);
    ext_manual_trigger_key_n_out <= 1'b0;
    repeat (lo) @(posedge clk_in);
    ext_manual_trigger_key_n_out <= 1'b1;
    repeat (20) @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

// *** testbench/meter_panel_key_controller_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
module meter_panel_key_controller_bench
  import mpkc_pkg::*;
;
  logic clk_in, rstn_in, avs_read_in, avs_write_in, avs_waitrequest_out;
  logic [3:0] avs_address_in, cal_pos_in, cal_pos_out;
  logic [31:0] avs_writedata_in, avs_readdata_out, rd;
  logic [NKEYS-1:0] keys_in;
  logic ext_manual_trigger_key_n_in, line_sel_60_in, auto_range_out, smooth_on_out, hold_out;
  logic buzzer_on_out, null_on_out, shift_marker_out, remote_out, power_up_disp_out;
  logic line_60_out, cal_pos_ind_out, cal_enable_out, meas_start_out, null_capture_out;
  logic [2:0] func_out, range_out, rate_out, smooth_idx_out, set_value_out, cal_cursor_out;
  logic [1:0] digits_out, set_mode_out;
  int bad_count = 0;
  int n_compared = 0;
  int n_meas = 0;
  int n_null = 0;
  int cyc = 0;
  int i;
  int em;

  // A short debounce interval keeps each press to a few dozen cycles.
  mpkc_key_ctrl #(.DEBOUNCE_CYCLES(4)) mpkc_key_ctrl_inst (
    .clk_in, .rstn_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
    .avs_readdata_out, .avs_waitrequest_out, .keys_in, .ext_manual_trigger_key_n_in, .line_sel_60_in,
    .cal_pos_in, .func_out, .range_out, .auto_range_out, .digits_out, .rate_out,
    .smooth_on_out, .smooth_idx_out, .hold_out, .buzzer_on_out, .null_on_out,
    .shift_marker_out, .remote_out, .set_mode_out, .set_value_out, .power_up_disp_out,
    .line_60_out, .cal_pos_ind_out, .cal_pos_out, .cal_enable_out, .cal_cursor_out,
    .meas_start_out, .null_capture_out
  );

  mpkc_panel_model mpkc_panel_model_inst (
    .clk_in(clk_in),
    .keys_out(keys_in),
    .ext_manual_trigger_key_n_out(ext_manual_trigger_key_n_in)
  );

  initial
  begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (meas_start_out === 1'b1)
      n_meas <= n_meas + 1;
    if (null_capture_out === 1'b1)
      n_null <= n_null + 1;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // The request stands until waitrequest is sampled low, then drops.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (avs_waitrequest_out !== 1'b0);
    check(n, 2);
    rd = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask

  task automatic key(input int k);
    mpkc_panel_model_inst.press(k, 20);
  endtask

  task automatic skey(input int k);
    key(K_SHIFT);
    key(k);
  endtask

  // The whole sequence needs about 4700 cycles; the ceiling leaves wide margin.
  always @(posedge clk_in)
  begin
    if (cyc == 40000)
    begin
      bad_count++;
      finish_test();
    end
  end

  initial
  begin
    rstn_in = 1'b0;
    avs_address_in = 4'h0;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_writedata_in = 32'h0;
    line_sel_60_in = 1'b1;
    cal_pos_in = 4'h3;
    repeat (10) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    check(power_up_disp_out, 1'h1);
    check(line_60_out, 1'h1);
    check({cal_pos_ind_out, cal_pos_out}, 5'h13);
    check({auto_range_out, digits_out, func_out}, {1'b1, DIG_5H, FN_DCV});
    cal_pos_in <= 4'h0;
    repeat (4) @(posedge clk_in);
    check(cal_pos_ind_out, 1'h0);
    key(K_SHIFT);
    check(shift_marker_out, 1'h1);
    mpkc_panel_model_inst.press(K_SHIFT, 80);
    check(shift_marker_out, 1'h0);
    key(K_UP);
    key(K_UP);
    check({auto_range_out, range_out}, 4'h2);
    key(K_ACV);
    check({func_out, range_out}, {FN_ACV, 3'h0});
    key(K_UP);
    key(K_DCV);
    check({func_out, range_out}, {FN_DCV, 3'h2});
    key(K_ACV);
    check(range_out, 3'h1);
    key(K_DCI);
    check(func_out, FN_DCI);
    key(K_ACI);
    check(func_out, FN_ACI);
    key(K_DCV);
    for (i = 0; i < 5; i++) key(K_UP);
    check(range_out, TOP_DCV);
    for (i = 0; i < 7; i++) key(K_DOWN);
    check(range_out, 3'h0);
    key(K_RANGE);
    check(auto_range_out, 1'h1);
    key(K_DOWN);
    check(auto_range_out, 1'h0);
    key(K_OHM);
    check(func_out, FN_OHM2);
    skey(K_OHM);
    check(func_out, FN_OHM4);
    key(K_RANGE);
    check(digits_out, DIG_3H);
    key(K_DOWN);
    check(digits_out, DIG_4H);
    key(K_UP);
    check(digits_out, DIG_5H);
    key(K_SHIFT);
    check(shift_marker_out, 1'h0);
    em = n_meas;
    key(K_RATE);
    check({rate_out, 8'(n_meas - em)}, {RATE_FAST, 8'h1});
    skey(K_RATE);
    check(set_mode_out, 2'h1);
    for (i = 0; i < 7; i++) key(K_UP);
    check(set_value_out, RATE_SLOWEST);
    key(K_DOWN);
    check(set_value_out, 3'h5);
    key(K_SHIFT);
    check({rate_out, set_mode_out, 8'(n_meas - em)}, {3'h5, 2'h0, 8'h2});
    key(K_SMOOTH);
    check(smooth_on_out, 1'h1);
    skey(K_SMOOTH);
    check(set_mode_out, 2'h3);
    key(K_DOWN);
    check(set_value_out, SMOOTH_MIN);
    key(K_UP);
    check(set_value_out, 3'h1);
    key(K_SHIFT);
    check({smooth_idx_out, set_mode_out}, {3'h1, 2'h0});
    key(K_HOLD);
    check(hold_out, 1'h1);
    em = n_meas;
    key(K_MANUAL_TRIGGER_KEY);
    mpkc_panel_model_inst.manual_trigger_key_pulse(1000);
    mpkc_panel_model_inst.manual_trigger_key_pulse(200);
    check(n_meas - em, 32'h2);
    skey(K_MANUAL_TRIGGER_KEY);
    check({buzzer_on_out, 8'(n_meas - em)}, {1'b1, 8'h2});
    key(K_SHIFT);
    key(K_HOLD);
    check(hold_out, 1'h0);
    mpkc_panel_model_inst.manual_trigger_key_pulse(1000);
    key(K_MANUAL_TRIGGER_KEY);
    check(n_meas - em, 32'h2);
    key(K_NULL);
    check({null_on_out, 8'(n_null)}, {1'b1, 8'h1});
    key(K_CAL);
    check(cal_enable_out, 1'h1);
    key(K_RANGE);
    check(cal_cursor_out, 3'h1);
    bus(1'b1, REG_CTRL, 32'h1);
    bus(1'b0, REG_CTRL, 32'h0);
    check({remote_out, rd}, {1'b1, 32'h1});
    key(K_DCI);
    check(func_out, FN_OHM4);
    key(K_SHIFT);
    check(remote_out, 1'h0);
    key(K_DCI);
    check(func_out, FN_DCI);
    bus(1'b0, REG_STATUS, 32'h0);
    check({rd[30:29], rd[2:0]}, {2'h0, FN_DCI});
    bus(1'b1, 4'h8, 32'h1);
    bus(1'b0, 4'h8, 32'h0);
    check({remote_out, rd}, 33'h0);
    finish_test();
  end
endmodule
`default_nettype wire
